// *** hdl/acms_consts.svh ***
// Purpose: Offsets, bit positions and timing counts of the clock monitor status block
// Assumes: Core clock of 20 MHz (50 ns)
// Notes:   Times are kept in ns; cycle counts are derived from them
`ifndef ACMS_CONSTS_SVH
`define ACMS_CONSTS_SVH

// Register offsets
`define ACMS_ADDR_DETECT     8'h5e
`define ACMS_ADDR_ERROR      8'h5f
`define ACMS_ADDR_MUTE       8'h6c

// Bit positions, detector flags
`define ACMS_DET_SYS_MISSING 6
`define ACMS_DET_BOTH_MISS   4
`define ACMS_DET_SYS_INVALID 2
`define ACMS_DET_BIT_INVALID 1
`define ACMS_DET_RATE_INV    0
// Bit positions, error flags
`define ACMS_ERR_HALT        4
`define ACMS_ERR_MISSING     2
`define ACMS_ERR_RESYNC      1
`define ACMS_ERR_CLOCK       0
// Bit positions, mute monitors
`define ACMS_MUTE_DUMMY_L    5
`define ACMS_MUTE_DUMMY_R    4
`define ACMS_MUTE_LEFT       1
`define ACMS_MUTE_RIGHT      0

// Bit clock ratio window, in bit clocks per frame
`define ACMS_BIT_RATIO_MIN   9'h020
`define ACMS_BIT_RATIO_MAX   9'h100
// Frame clock low period at or under this many bit clocks is flagged
`define ACMS_FRAME_LOW_BITS  9'h005

// Timing
`define ACMS_CLK_NS          50
`define ACMS_BIT_LOST_NS     2000
`define ACMS_FRAME_LOST_NS   100000
`define ACMS_SYS_LOST_NS     1000
`define ACMS_RESYNC_NS       10000
`define ACMS_CYC(ns)         ((ns + `ACMS_CLK_NS - 1) / `ACMS_CLK_NS)

`endif

// *** hdl/acms_pkg.sv ***
// Purpose: Types shared by the clock monitor status block
// Assumes: Nothing beyond the constants header
// Notes:   Pin group and live detector flags travel as packed structs
`default_nettype none
package acms_pkg;
  // Pins sampled from outside the core clock domain
  typedef struct packed {
    logic bit_clock;
    logic frame_clock;
    logic sys_clock;
    logic left_mute_n;
    logic right_mute_n;
    logic dummy_left_mute_n;
    logic dummy_right_mute_n;
  } acms_pins_s;

  // Live detector conditions
  typedef struct packed {
    logic sys_missing;
    logic both_missing;
    logic sys_invalid;
    logic bit_invalid;
    logic rate_invalid;
    logic clock_error;
  } acms_detect_s;
endpackage
`default_nettype wire

// *** hdl/acms_monitor.sv ***
// Purpose: Clock detector and read-only status registers of the audio clock monitor
// Assumes: Link clocks and mute levels arrive asynchronously and are sampled at 20 MHz
// Notes:   Reads return data one cycle after the request; reading the error register clears the halt latch
`include "acms_consts.svh"
`default_nettype none

module acms_monitor (
  input  wire logic                clock,         // Core clock, 20 MHz
  input  wire logic                rstn,          // Asynchronous reset, active low
  input  wire acms_pkg::acms_pins_s pins,         // Link clocks and mute levels
  input  wire logic                ignore_errors, // Error handling set to ignore errors; hides only rate_invalid
  input  wire logic                rd_en,         // Register read strobe
  input  wire logic [7:0]          rd_addr,       // Register offset
  output logic      [7:0]          rd_data,       // Read data, one cycle later
  output logic                     rd_valid       // Read data valid pulse
);
  localparam logic [11:0] BIT_CYC    = 12'(`ACMS_CYC(`ACMS_BIT_LOST_NS));
  localparam logic [11:0] FRAME_CYC  = 12'(`ACMS_CYC(`ACMS_FRAME_LOST_NS));
  localparam logic [11:0] SYS_CYC    = 12'(`ACMS_CYC(`ACMS_SYS_LOST_NS));
  localparam logic [11:0] RESYNC_CYC = 12'(`ACMS_CYC(`ACMS_RESYNC_NS));

  acms_pkg::acms_pins_s sync1;      // First synchroniser stage
  acms_pkg::acms_pins_s sync2;      // Second stage, safe to use
  acms_pkg::acms_pins_s sync3;      // Delayed copy for edge finding
  logic [11:0]          bit_timer;  // Cycles since last bit clock edge
  logic [11:0]          frame_timer;// Cycles since last frame clock edge
  logic [11:0]          sys_timer;  // Cycles since last system clock edge
  logic [8:0]           bit_cnt;    // Bit clocks in current frame
  logic [8:0]           low_cnt;    // Bit clocks while frame clock low
  logic [8:0]           bit_ratio;  // Bit clocks in last frame
  logic [8:0]           prev_ratio; // Bit clocks in frame before that
  logic [8:0]           low_bits;   // Low period of last frame
  logic                 sys_seen;   // System clock edge seen this frame
  logic                 sys_ok;     // Last frame held system clock edges
  acms_pkg::acms_detect_s detect;   // Registered detector flags
  acms_pkg::acms_detect_s next_detect;
  logic                 halt_latch; // Sticky system clock halt
  logic [11:0]          resync_cnt; // Resync cycles remaining
  logic [3:0]           mute_q;     // Registered mute monitors

  // Saturating timer, cleared by an edge
  function automatic logic [11:0] timer_step(input logic [11:0] t, input logic clr);
    return clr ? 12'h000 : ((t == 12'hfff) ? t : t + 12'h001);
  endfunction

  wire bit_rise   = sync2.bit_clock & ~sync3.bit_clock;
  wire frame_rise = sync2.frame_clock & ~sync3.frame_clock;
  wire bit_edge   = sync2.bit_clock ^ sync3.bit_clock;
  wire frame_edge = sync2.frame_clock ^ sync3.frame_clock;
  wire sys_edge   = sync2.sys_clock ^ sync3.sys_clock;
  wire halt_set   = next_detect.sys_missing & ~detect.sys_missing;
  wire err_read   = rd_en && (rd_addr == `ACMS_ADDR_ERROR);

  // Two flops before any logic looks at the pins
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Activity timers; a dead clock stops clearing its timer
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bit_timer   <= 12'hfff;
      frame_timer <= 12'hfff;
      sys_timer   <= 12'hfff;
    end else begin
      bit_timer   <= timer_step(bit_timer, bit_edge);
      frame_timer <= timer_step(frame_timer, frame_edge);
      sys_timer   <= timer_step(sys_timer, sys_edge);
    end
  end

  // Per-frame measurement, captured at each frame clock rise
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bit_cnt    <= 9'h000;
      low_cnt    <= 9'h000;
      bit_ratio  <= 9'h000;
      prev_ratio <= 9'h000;
      low_bits   <= 9'h000;
      sys_seen   <= 1'b0;
      sys_ok     <= 1'b0;
    end else if (frame_rise) begin
      bit_ratio  <= bit_cnt;
      prev_ratio <= bit_ratio;
      low_bits   <= low_cnt;
      sys_ok     <= sys_seen;
      bit_cnt    <= {8'h00, bit_rise};
      low_cnt    <= 9'h000;
      sys_seen   <= sys_edge;
    end else begin
      // Saturate so very long frames read as out of range
      if (bit_rise && bit_cnt != 9'h1ff) bit_cnt <= bit_cnt + 9'h001;
      if (bit_rise && !sync2.frame_clock && low_cnt != 9'h1ff) low_cnt <= low_cnt + 9'h001;
      if (sys_edge) sys_seen <= 1'b1;
    end
  end

  // Live detector conditions
  always_comb begin
    logic frame_lost;
    logic bit_lost;
    frame_lost = (frame_timer >= FRAME_CYC);
    bit_lost   = (bit_timer >= BIT_CYC);
    next_detect.sys_missing  = (sys_timer >= SYS_CYC);
    next_detect.both_missing = frame_lost & bit_lost & ~sync2.frame_clock & ~sync2.bit_clock;
    next_detect.sys_invalid  = next_detect.sys_missing | ~sys_ok | frame_lost
                             | (low_bits <= `ACMS_FRAME_LOW_BITS);
    next_detect.bit_invalid  = frame_lost | (bit_ratio != prev_ratio)
                             | (bit_ratio < `ACMS_BIT_RATIO_MIN)
                             | (bit_ratio > `ACMS_BIT_RATIO_MAX);
    // Undetectable rate is hidden when errors are ignored
    next_detect.rate_invalid = frame_lost & ~ignore_errors;
    next_detect.clock_error  = next_detect.sys_missing | next_detect.sys_invalid
                             | next_detect.bit_invalid | next_detect.rate_invalid;
  end

  // Status follows the detector every cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      detect <= '0;
      mute_q <= 4'h0;
    end else begin
      detect <= next_detect;
      mute_q <= {sync2.dummy_left_mute_n, sync2.dummy_right_mute_n,
                 sync2.left_mute_n, sync2.right_mute_n};
    end
  end

  // Halt latch; a new halt in the read cycle wins over the clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) halt_latch <= 1'b0;
    else if (halt_set) halt_latch <= 1'b1;
    else if (err_read) halt_latch <= 1'b0;
  end

  // Resync window starts when a clock error goes away
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) resync_cnt <= 12'h000;
    else if (next_detect.clock_error) resync_cnt <= 12'h000;
    else if (detect.clock_error) resync_cnt <= RESYNC_CYC;
    else if (resync_cnt != 12'h000) resync_cnt <= resync_cnt - 12'h001;
  end

  // Read port; unmapped offsets read as zero, reserved bits as zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      rd_data  <= 8'h00;
      if (rd_en) begin
        case (rd_addr)
          `ACMS_ADDR_DETECT: begin
            rd_data[`ACMS_DET_SYS_MISSING] <= detect.sys_missing;
            rd_data[`ACMS_DET_BOTH_MISS]   <= detect.both_missing;
            rd_data[`ACMS_DET_SYS_INVALID] <= detect.sys_invalid;
            rd_data[`ACMS_DET_BIT_INVALID] <= detect.bit_invalid;
            rd_data[`ACMS_DET_RATE_INV]    <= detect.rate_invalid;
          end
          `ACMS_ADDR_ERROR: begin
            rd_data[`ACMS_ERR_HALT]    <= halt_latch;
            rd_data[`ACMS_ERR_MISSING] <= detect.both_missing;
            rd_data[`ACMS_ERR_RESYNC]  <= (resync_cnt != 12'h000);
            rd_data[`ACMS_ERR_CLOCK]   <= detect.clock_error;
          end
          `ACMS_ADDR_MUTE: begin
            rd_data[`ACMS_MUTE_DUMMY_L] <= mute_q[3];
            rd_data[`ACMS_MUTE_DUMMY_R] <= mute_q[2];
            rd_data[`ACMS_MUTE_LEFT]    <= mute_q[1];
            rd_data[`ACMS_MUTE_RIGHT]   <= mute_q[0];
          end
          default: rd_data <= 8'h00;
        endcase
      end
    end
  end

  // Checks; timeout checks start only once the sampled reset is high, since at the
  // release edge the flags still hold their reset values
  property p_bit_short;
    @(posedge clock) disable iff (!rstn)
    frame_rise && (bit_cnt < `ACMS_BIT_RATIO_MIN) |=> ##1 detect.bit_invalid;
  endproperty
  a_bit_short: assert property (p_bit_short) else $error("short bit clock ratio not flagged");

  property p_rate_lost;
    @(posedge clock) disable iff (!rstn)
    rstn && (frame_timer >= FRAME_CYC) && !ignore_errors |=> detect.rate_invalid;
  endproperty
  a_rate_lost: assert property (p_rate_lost) else $error("lost frame clock not flagged");

  property p_rate_ignored;
    @(posedge clock) disable iff (!rstn)
    ignore_errors |=> !detect.rate_invalid;
  endproperty
  a_rate_ignored: assert property (p_rate_ignored) else $error("rate flag shown while ignored");

  property p_halt_read;
    @(posedge clock) disable iff (!rstn)
    err_read && halt_latch |=> rd_valid && rd_data[`ACMS_ERR_HALT] && (halt_latch == $past(halt_set));
  endproperty
  a_halt_read: assert property (p_halt_read) else $error("halt latch read or clear wrong");

  property p_missing_low;
    @(posedge clock) disable iff (!rstn)
    detect.both_missing |-> $past(!sync2.bit_clock && !sync2.frame_clock);
  endproperty
  a_missing_low: assert property (p_missing_low) else $error("missing flag with clocks high");

  property p_resync_hold;
    @(posedge clock) disable iff (!rstn)
    $fell(detect.clock_error) && !next_detect.clock_error ##1 !next_detect.clock_error[*7]
      |-> (resync_cnt != 12'h000);
  endproperty
  a_resync_hold: assert property (p_resync_hold) else $error("resync window ended early");

  property p_error_any;
    @(posedge clock) disable iff (!rstn)
    detect.bit_invalid || detect.sys_missing |-> detect.clock_error;
  endproperty
  a_error_any: assert property (p_error_any) else $error("clock error flag missing");

  property p_mute_read;
    @(posedge clock) disable iff (!rstn)
    rd_en && (rd_addr == `ACMS_ADDR_MUTE)
      |=> rd_data[`ACMS_MUTE_DUMMY_L] == $past(sync3.dummy_left_mute_n)
       && rd_data[`ACMS_MUTE_RIGHT] == $past(sync3.right_mute_n);
  endproperty
  a_mute_read: assert property (p_mute_read) else $error("mute monitor read wrong");

  property p_sys_lost;
    @(posedge clock) disable iff (!rstn)
    rstn && (sys_timer >= SYS_CYC) |=> detect.sys_missing && detect.sys_invalid;
  endproperty
  a_sys_lost: assert property (p_sys_lost) else $error("system clock loss not flagged");

  property p_short_low;
    @(posedge clock) disable iff (!rstn)
    rstn && (low_bits <= `ACMS_FRAME_LOW_BITS) |=> detect.sys_invalid;
  endproperty
  a_short_low: assert property (p_short_low) else $error("short frame low not flagged");

  property p_detect_read;
    @(posedge clock) disable iff (!rstn)
    rd_en && (rd_addr == `ACMS_ADDR_DETECT) |=> rd_data[`ACMS_DET_BIT_INVALID] == $past(detect.bit_invalid);
  endproperty
  a_detect_read: assert property (p_detect_read) else $error("detector read not live");
endmodule // acms_monitor
`default_nettype wire

// *** tb/acms_source.sv ***
// Purpose: Audio serial source model driving bit, frame and system clocks
// Assumes: Bit clock period 400 ns, system clock period 100 ns
// Notes:   Stopped clocks are held low, as a halted source would leave them
`default_nettype none
module acms_source (
  input  wire logic       run_bits,    // Bit and frame clocks toggle when high
  input  wire logic       run_sys,     // System clock toggles when high
  input  wire logic [8:0] ratio,       // Bit clocks per frame
  output logic            bit_clock,   // Serial bit clock
  output logic            frame_clock, // Frame clock, high for first half
  output logic            sys_clock    // System clock
);
  timeunit 1ns;
  timeprecision 1ns;

  // System clock; held low while stopped so the halt is seen
  initial begin
    sys_clock = 1'b0;
    forever begin
      #50;
      sys_clock = run_sys ? ~sys_clock : 1'b0;
    end
  end

  // Bit and frame clocks; frame edges land on bit clock falls
  initial begin
    bit_clock   = 1'b0;
    frame_clock = 1'b0;
    forever begin
      if (!run_bits) begin
        // Both tied low while absent
        bit_clock   = 1'b0;
        frame_clock = 1'b0;
        #200;
      end else begin
        // Ratio is sampled each bit, so a change splits one frame only
        for (int i = 0; i < ratio; i++) begin
          frame_clock = (i < ratio / 2);
          bit_clock   = 1'b0;
          #200;
          bit_clock   = 1'b1;
          #200;
        end
      end
    end
  end
endmodule // acms_source
`default_nettype wire

// *** tb/acms_monitor_bench.sv ***
// Purpose: Self-checking bench of the clock monitor status registers
// Assumes: 20 MHz core clock, register reads answered one cycle later
// Notes:   Only whole-register reads are made; nothing is ever written
`include "acms_consts.svh"
`default_nettype none
module acms_monitor_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic                 clock;         // Core clock
  logic                 rstn;          // Reset, active low
  logic                 bit_clk;       // Bit clock from source
  logic                 frame_clk;     // Frame clock from source
  logic                 sys_clk;       // System clock from source
  logic [3:0]           mute_n;        // Left, right, dummy left, dummy right
  logic                 run_bits;      // Source control
  logic                 run_sys;       // Source control
  logic [8:0]           ratio;         // Source bit clocks per frame
  logic                 ignore_errors; // Error handling ignores errors
  logic                 rd_en;         // Read strobe
  logic [7:0]           rd_addr;       // Read offset
  logic [7:0]           rd_data;       // Read data
  logic                 rd_valid;      // Read data valid
  logic [7:0]           v;             // Last read value
  acms_pkg::acms_pins_s pins;          // Pin group
  int                   err_total;     // Mismatch count
  int                   n_checks;      // Comparison count
  logic [8:0]           rt [3] = '{9'h010, 9'h00a, 9'h020}; // Ratios tried
  logic [7:0]           rx [3] = '{8'h02, 8'h06, 8'h00};    // Detector flags expected

  assign pins = {bit_clk, frame_clk, sys_clk, mute_n};

  acms_source acms_source_inst (
    .run_bits    (run_bits),
    .run_sys     (run_sys),
    .ratio       (ratio),
    .bit_clock   (bit_clk),
    .frame_clock (frame_clk),
    .sys_clock   (sys_clk)
  );

  acms_monitor acms_monitor_inst (
    .clock         (clock),
    .rstn          (rstn),
    .pins          (pins),
    .ignore_errors (ignore_errors),
    .rd_en         (rd_en),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_valid      (rd_valid)
  );

  // Core clock, 50 ns period
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Compare and count
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask

  // One read: strobe for one edge, data settled after the next
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    rd_en   <= 1'b1;
    rd_addr <= a;
    @(posedge clock);
    rd_en   <= 1'b0;
    #1;
    v = rd_data;
    chk("rd_valid", 8'h01, {7'h00, rd_valid});
  endtask

  // Verdict, reached from the sequence or the watchdog
  task automatic summarize;
    if (err_total == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs about 10000 cycles
  initial begin
    #2000000;
    err_total++;
    summarize();
  end

  // Main sequence
  initial begin
    err_total = 0;
    n_checks  = 0;
    rstn = 1'b0; rd_en = 1'b0; rd_addr = 8'h00; ignore_errors = 1'b0;
    mute_n = 4'h0; run_bits = 1'b0; run_sys = 1'b0; ratio = 9'h040;
    wt(20);
    rstn <= 1'b1;
    // All clocks absent long enough for every timeout
    wt(2500);
    rd(`ACMS_ADDR_DETECT); chk("detect idle", 8'h57, v);
    rd(`ACMS_ADDR_ERROR);  chk("error first", 8'h15, v);
    rd(`ACMS_ADDR_ERROR);  chk("error idle", 8'h05, v);
    rd(8'h00);             chk("unmapped", 8'h00, v);
    ignore_errors <= 1'b1;
    wt(4);
    rd(`ACMS_ADDR_DETECT); chk("ignore", 8'h56, v);
    ignore_errors <= 1'b0;
    // Clocks start; poll until the error clears, then resync shows
    run_sys <= 1'b1; run_bits <= 1'b1;
    v = 8'h01;
    for (int i = 0; i < 3000 && v[0] !== 1'b0; i++) rd(`ACMS_ADDR_ERROR);
    rd(`ACMS_ADDR_ERROR);  chk("resync", 8'h02, v);
    wt(250);
    rd(`ACMS_ADDR_ERROR);  chk("resync done", 8'h00, v);
    rd(`ACMS_ADDR_DETECT); chk("detect ok", 8'h00, v);
    // Ratio out of range, short frame low, lowest legal ratio
    for (int i = 0; i < 3; i++) begin
      ratio <= rt[i];
      wt(1500);
      rd(`ACMS_ADDR_DETECT); chk("ratio", rx[i], v);
    end
    // System clock halt, then recovery
    run_sys <= 1'b0;
    wt(60);
    rd(`ACMS_ADDR_DETECT); chk("halted", 8'h44, v);
    run_sys <= 1'b1;
    wt(1500);
    rd(`ACMS_ADDR_ERROR);  chk("halt latch", 8'h10, v);
    rd(`ACMS_ADDR_ERROR);  chk("halt clear", 8'h00, v);
    // Mute monitors, alternating patterns
    mute_n <= 4'ha;
    wt(4);
    rd(`ACMS_ADDR_MUTE);   chk("mute a", 8'h22, v);
    mute_n <= 4'h5;
    wt(4);
    rd(`ACMS_ADDR_MUTE);   chk("mute b", 8'h11, v);
    summarize();
  end
endmodule // acms_monitor_bench
`default_nettype wire
